// ===== hw/eil_defines.vh
// Constants for the event interrupt logic: offsets, field positions, reset values.
`ifndef EIL_DEFINES_VH
`define EIL_DEFINES_VH

// Register offsets on the host register port
`define EIL_ADDR_W 8
`define EIL_OFF_MASK 8'h6c
`define EIL_OFF_STATUS 8'h7e

// Register width
`define EIL_REG_W 16

// Event bit positions, shared by the status and mask registers
`define EIL_NUM_EVT 4
`define EIL_BIT_TX_THRESH 0
`define EIL_BIT_RX_THRESH 1
`define EIL_BIT_RX_OVERFLOW 2
`define EIL_BIT_TX_DONE 3

// Global mask bit in the mask register, line state bit in the status register
`define EIL_BIT_GLOBAL 15
`define EIL_BIT_LINE 15

// Reset values
`define EIL_MASK_RST 16'h0000
`define EIL_RDATA_RST 16'h0000

// FIFO level width
`define EIL_LVL_W 8

`endif

// ===== hw/eil_sticky_flag.v
// One latched event flag with rising-edge capture and set-over-clear priority.
`default_nettype none

module eil_sticky_flag (
	input wire sys_clk,
	input wire srst,
	input wire evt_lvl,
	input wire clr,
	output reg flag_r
);

	reg evt_dly_r;
	wire evt_set;
	wire flag_nxt;

	// A level that stays high sets the flag only once
	assign evt_set = evt_lvl & ~evt_dly_r;
	// An event in the clearing cycle is kept
	assign flag_nxt = evt_set | (flag_r & ~clr);

	always @(posedge sys_clk) begin
		if (srst) begin
			evt_dly_r <= 1'b0;
			flag_r <= 1'b0;
		end else begin
			evt_dly_r <= evt_lvl;
			flag_r <= flag_nxt;
		end
	end

endmodule

`default_nettype wire

// ===== hw/eil_top.v
// Event interrupt logic: status flags, mask register and active-low host interrupt line.
//
// How it works
// R1: Every source has own flag and mask bit
// R2: Events: FIFO thresholds, receive overflow, transmit done
// R3: Only unmasked flags drive the request line
// R4: Mask bit 15 gates all sources together
// R5: Unmasking an already set flag raises request
// R6: Status bit 15 mirrors request line state
// R7: Status read command phase clears all flags
// R8: Transmit threshold when level falls below threshold
// R9: Receive threshold when level rises above threshold
// R10: Request line is active low
`include "eil_defines.vh"
`default_nettype none

module eil_top (
	input wire sys_clk,
	input wire srst,
	// Host register port
	input wire reg_wr_en,
	input wire reg_rd_en,
	input wire [`EIL_ADDR_W-1:0] reg_addr,
	input wire [`EIL_REG_W-1:0] reg_wdata,
	output reg [`EIL_REG_W-1:0] reg_rdata_r,
	output reg reg_rvalid_r,
	// Event sources
	input wire [`EIL_LVL_W-1:0] tx_fifo_level,
	input wire [`EIL_LVL_W-1:0] tx_fifo_thresh,
	input wire [`EIL_LVL_W-1:0] rx_fifo_level,
	input wire [`EIL_LVL_W-1:0] rx_fifo_thresh,
	input wire rx_overflow_evt,
	input wire tx_mode_active,
	input wire tx_done_evt,
	// Host interrupt request
	output wire host_interrupt_line_n
);

	reg [`EIL_REG_W-1:0] mask_r;
	reg irq_r;
	wire irq_nxt;
	wire [`EIL_NUM_EVT-1:0] evt_lvl;
	wire [`EIL_NUM_EVT-1:0] flags;
	wire [`EIL_NUM_EVT-1:0] flag_clr;
	wire [`EIL_NUM_EVT-1:0] evt_mask;
	wire status_rd;
	wire mask_wr;
	wire [`EIL_REG_W-1:0] status_word;

	// Event conditions
	assign evt_lvl[`EIL_BIT_TX_THRESH] = (tx_fifo_level < tx_fifo_thresh); // [R2] [R8]
	assign evt_lvl[`EIL_BIT_RX_THRESH] = (rx_fifo_level > rx_fifo_thresh); // [R2] [R9]
	assign evt_lvl[`EIL_BIT_RX_OVERFLOW] = rx_overflow_evt; // [R2]
	assign evt_lvl[`EIL_BIT_TX_DONE] = tx_done_evt & tx_mode_active; // [R2]

	// Register decode
	assign status_rd = reg_rd_en && (reg_addr == `EIL_OFF_STATUS);
	assign mask_wr = reg_wr_en && (reg_addr == `EIL_OFF_MASK);

	// Reading status clears every flag at once
	assign flag_clr = {`EIL_NUM_EVT{status_rd}}; // [R7]

	genvar gi;
	generate
		for (gi = 0; gi < `EIL_NUM_EVT; gi = gi + 1) begin : g_flag
			eil_sticky_flag u_flag (
				.sys_clk(sys_clk),
				.srst(srst),
				.evt_lvl(evt_lvl[gi]),
				.clr(flag_clr[gi]),
				.flag_r(flags[gi])
			); // [R1]
		end
	endgenerate

	assign evt_mask = mask_r[`EIL_NUM_EVT-1:0];

	// Level function of flags and mask, so a later unmask also fires
	assign irq_nxt = (|(flags & evt_mask)) & mask_r[`EIL_BIT_GLOBAL]; // [R3] [R4] [R5]

	// Mask register, write only
	always @(posedge sys_clk) begin
		if (srst) begin
			mask_r <= `EIL_MASK_RST;
		end else if (mask_wr) begin
			mask_r <= reg_wdata; // [R1]
		end
	end

	// Request state; cleared alongside the flags on a status read
	always @(posedge sys_clk) begin
		if (srst) begin
			irq_r <= 1'b0;
		end else if (status_rd) begin
			irq_r <= 1'b0; // [R7]
		end else begin
			irq_r <= irq_nxt;
		end
	end

	assign host_interrupt_line_n = ~irq_r; // [R10]

	// Status word: line state in the top bit, flags in the low bits
	assign status_word = {irq_r, {(`EIL_REG_W-1-`EIL_NUM_EVT){1'b0}}, flags}; // [R6]

	// Read data; unmapped and write-only addresses read as zero
	always @(posedge sys_clk) begin
		if (srst) begin
			reg_rdata_r <= `EIL_RDATA_RST;
			reg_rvalid_r <= 1'b0;
		end else begin
			reg_rvalid_r <= reg_rd_en;
			if (status_rd) begin
				reg_rdata_r <= status_word;
			end else if (reg_rd_en) begin
				reg_rdata_r <= `EIL_RDATA_RST;
			end
		end
	end

endmodule

`default_nettype wire

// ===== hw/eil_unused_placeholder_removed.v
// Intentionally empty design unit list terminator.
`default_nettype none
`default_nettype wire

// ===== bench/eil_monitor.sv
// Port assertions for the event interrupt logic
`default_nettype none
module eil_monitor(
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata_r,
	input wire logic reg_rvalid_r,
	input wire logic host_interrupt_line_n
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	sequence st_rd;
		reg_rd_en && reg_addr == 8'h7e;
	endsequence
	rd_valid_a: assert property (reg_rd_en |=> reg_rvalid_r) else $error("no rvalid");
	rv_pulse_a: assert property (!reg_rd_en |=> !reg_rvalid_r) else $error("extra rvalid");
	clr_line_a: assert property (st_rd |=> host_interrupt_line_n) else $error("line kept");
	bit_mirror_a: assert property (st_rd |=> reg_rdata_r[15] == !$past(host_interrupt_line_n))
		else $error("bit 15 wrong");
	mask_off_a: assert property (reg_wr_en && reg_addr == 8'h6c && !reg_wdata[15]
		|-> ##2 host_interrupt_line_n) else $error("global mask");
	other_rd_a: assert property (reg_rd_en && reg_addr != 8'h7e |=> reg_rdata_r == 16'h0000)
		else $error("nonzero read");
	fall_cause_a: assert property ($fell(host_interrupt_line_n)
		|-> !($past(reg_rd_en) && $past(reg_addr) == 8'h7e)) else $error("fall");
	hold_data_a: assert property (!reg_rd_en |=> $stable(reg_rdata_r)) else $error("rdata");
endmodule
bind eil_top eil_monitor eil_monitor_i(.*);
`default_nettype wire

// ===== bench/eil_host_mdl.sv
// Host model: keeps the word returned by each register read
`default_nettype none
module eil_host_mdl(
	input wire logic sys_clk,
	input wire logic reg_rvalid_r,
	input wire logic [15:0] reg_rdata_r,
	output logic [15:0] seen
);
	timeunit 1ns;
	timeprecision 1ps;
	always @(posedge sys_clk) if (reg_rvalid_r) seen <= reg_rdata_r;
endmodule
`default_nettype wire

// ===== bench/eil_tb_top.sv
// Testbench for the event interrupt logic
`default_nettype none
module eil_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 0, srst = 1, reg_wr_en = 0, reg_rd_en = 0;
	logic rx_overflow_evt = 0, tx_mode_active = 0, tx_done_evt = 0;
	logic [7:0] reg_addr = 0, tx_fifo_level = 0, tx_fifo_thresh = 0;
	logic [7:0] rx_fifo_level = 0, rx_fifo_thresh = 0;
	logic [15:0] reg_wdata = 0, reg_rdata_r, seen;
	logic reg_rvalid_r, host_interrupt_line_n;
	int num_errors = 0, comparisons = 0;
	eil_top eil_top_i(.*);
	eil_host_mdl eil_host_mdl_i(.*);
	initial forever #2.5 sys_clk = ~sys_clk;
	task final_report;
		$display("comparisons=%0d errors=%0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task chk(input logic [15:0] s, input logic [15:0] e);
		comparisons++;
		if (s !== e) begin
			num_errors++;
			$display("unexpected t=%0t got=%h exp=%h", $time, s, e);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task wr(input logic [15:0] d);
		@(posedge sys_clk) reg_wr_en <= 1;
		reg_addr <= 8'h6c;
		reg_wdata <= d;
		@(posedge sys_clk) reg_wr_en <= 0;
	endtask
	task rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge sys_clk) reg_rd_en <= 1;
		reg_addr <= a;
		@(posedge sys_clk) reg_rd_en <= 0;
		cyc(1);
		#1 chk(seen, e);
	endtask
	task ev(input logic t);
		@(posedge sys_clk) rx_overflow_evt <= 1;
		tx_done_evt <= 1;
		tx_mode_active <= t;
		@(posedge sys_clk) rx_overflow_evt <= 0;
		tx_done_evt <= 0;
	endtask
	initial begin
		#20000 num_errors++;
		final_report;
	end
	initial begin
		cyc(12);
		srst <= 0;
		cyc(2);
		#1 chk(host_interrupt_line_n, 1);
		ev(0);
		cyc(3);
		#1 chk(host_interrupt_line_n, 1);
		rd(8'h7e, 16'h0004);
		ev(0);
		wr(16'h0004);
		cyc(3);
		#1 chk(host_interrupt_line_n, 1);
		wr(16'h8004);
		cyc(2);
		#1 chk(host_interrupt_line_n, 0);
		rd(8'h6c, 16'h0000);
		chk(host_interrupt_line_n, 0);
		rd(8'h7e, 16'h8004);
		chk(host_interrupt_line_n, 1);
		rd(8'h7e, 16'h0000);
		wr(16'h800f);
		tx_fifo_thresh <= 8'h10;
		rx_fifo_thresh <= 8'h10;
		tx_fifo_level <= 8'h20;
		@(posedge sys_clk) tx_fifo_level <= 8'h05;
		rx_fifo_level <= 8'h20;
		ev(1);
		cyc(3);
		#1 chk(host_interrupt_line_n, 0);
		rd(8'h7e, 16'h800f);
		rd(8'h7e, 16'h0000);
		final_report;
	end
endmodule
`default_nettype wire
